// [pbm_pkg.sv]
// constants and field layouts for the protection bit map decoder
// Behaviour
// - each section entry holds type, count, start field and end field in order
// - the first size entry, 8 kbyte blocks, is type code 01h
// - second, third and fourth size entries are type codes 02h, 03h and 04h
// - a repeated block size is its own independent section entry
// - only protection-governed blocks appear; uniform small erase sectors never do
// - bottom-up order: four small, one medium, large run, one medium, four small
// - 8 kbyte is type 1, 32 kbyte type 2, 64 kbyte type 3
// - large block count is two to the exponent minus two
// - density exponent is 4 to 8 for 8 to 128 megabit
// - a start field of 00h means protection bit zero
// - nonzero field is signed adder c; position is two to exponent plus one plus c
// - in medium and large sections positions rise by one per block and span equals the block count; small sections are flagged
// - bottom small section adders are 0ffh start and 04h end
// - medium sections use one bit: adder 0fdh lower, 0feh upper
// - large section starts at bit zero and ends at adder 0fch
// - top small section adders are 07h start and 0eh end
// - in small sections odd positions are read lock, even are write lock
package pbm_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0c;
  localparam logic [7:0] ADDR_CNT = 8'h10;
  localparam logic [7:0] ADDR_ROLE = 8'h14;
  localparam logic [7:0] ADDR_QRY = 8'h18;
  localparam logic [2:0] TBL_PAGE = 3'h1;
  localparam int NSEC = 5;
  localparam logic [2:0] LAST_SEC = 3'h4;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_M_LSB = 0;
  localparam int CFG_SEL_LSB = 8;
  localparam int CMD_FILL_BIT = 0;
  localparam int CMD_DEC_BIT = 1;
  localparam int F_TYPE = 0;
  localparam int F_CNT = 8;
  localparam int F_START = 16;
  localparam int F_END = 24;
  localparam int POS_W = 10;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [3:0] M_RST = 4'h7;
  localparam logic [3:0] M_MIN = 4'h4;
  localparam logic [3:0] M_MAX = 4'h8;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [7:0] TYPE_8K = 8'h01;
  localparam logic [7:0] TYPE_32K = 8'h02;
  localparam logic [7:0] TYPE_64K = 8'h03;
  localparam logic [7:0] TYPE_4TH = 8'h04;
  localparam logic [7:0] FIELD_ZERO = 8'h00;
  localparam logic [7:0] ADD_SMALL_LO_S = 8'hff;
  localparam logic [7:0] ADD_SMALL_LO_E = 8'h04;
  localparam logic [7:0] ADD_MED_LO = 8'hfd;
  localparam logic [7:0] ADD_LARGE_E = 8'hfc;
  localparam logic [7:0] ADD_MED_HI = 8'hfe;
  localparam logic [7:0] ADD_SMALL_HI_S = 8'h07;
  localparam logic [7:0] ADD_SMALL_HI_E = 8'h0e;
  localparam logic [7:0] CNT_CODE_SMALL = 8'h02;
  localparam logic [7:0] CNT_CODE_MED = 8'h00;
  localparam logic [POS_W-1:0] LARGE_LESS = 10'h002;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [pbm_tbl_mem.sv]
// section table storage with a registered read port
`timescale 1ns/1ps
module pbm_tbl_mem
  import pbm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_data
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [31:0] mem_ff [NSEC];
  logic [31:0] rd_data_ff;

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_ff <= 32'h0;
    end else begin
      rd_data_ff <= (rd_idx <= LAST_SEC) ? mem_ff[rd_idx] : 32'h0;
    end
  end

  assign rd_data = rd_data_ff;
endmodule // pbm_tbl_mem

// [pbm_decoder.sv]
// protection bit map decoder with axi4-lite register access
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module pbm_decoder
  import pbm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [POS_W-1:0] pow2(input logic [3:0] e);
    return {{(POS_W-1){1'b0}}, 1'b1} << e;
  endfunction

  // start or end field to absolute bit position
  function automatic logic [POS_W-1:0] bit_pos(input logic [7:0] f,
                                               input logic [3:0] e);
    logic [POS_W-1:0] sext;
    sext = {{(POS_W-8){f[7]}}, f};
    if (f == FIELD_ZERO) begin
      return '0;
    end
    return pow2(e) + 10'h001 + sext;
  endfunction

  // default entry of each section, bottom of the array upward
  function automatic logic [31:0] gen_entry(input logic [2:0] idx,
                                            input logic [3:0] e);
    logic [31:0] ent;
    ent = 32'h0;
    unique case (idx)
      3'h0: ent = {ADD_SMALL_LO_E, ADD_SMALL_LO_S, CNT_CODE_SMALL, TYPE_8K};
      3'h1: ent = {ADD_MED_LO, ADD_MED_LO, CNT_CODE_MED, TYPE_32K};
      3'h2: ent = {ADD_LARGE_E, FIELD_ZERO, {4'h0, e}, TYPE_64K};
      3'h3: ent = {ADD_MED_HI, ADD_MED_HI, CNT_CODE_MED, TYPE_32K};
      3'h4: ent = {ADD_SMALL_HI_E, ADD_SMALL_HI_S, CNT_CODE_SMALL, TYPE_8K};
      default: ent = 32'h0;
    endcase
    return ent;
  endfunction

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ENG_IDLE, ENG_FILL, ENG_FETCH, ENG_CALC} pbm_eng_t;

  pbm_eng_t eng_ff;
  pbm_eng_t nxt_eng;
  logic [2:0] fill_idx_ff;
  logic [3:0] m_ff;
  logic [2:0] sel_ff;
  logic [POS_W-1:0] qry_ff;
  logic [POS_W-1:0] start_pos_ff;
  logic [POS_W-1:0] end_pos_ff;
  logic [POS_W-1:0] blocks_ff;
  logic [7:0] type_ff;
  logic span_bad_ff;
  logic type_bad_ff;
  logic dec_valid_ff;

  logic aw_full_ff;
  logic w_full_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic rd_pend_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire eng_idle = (eng_ff == ENG_IDLE);
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire do_wr = aw_full_ff && w_full_ff && !bvalid_ff && eng_idle;

  wire wr_tbl = (awaddr_ff[7:5] == TBL_PAGE) && (awaddr_ff[4:2] <= LAST_SEC);
  wire wr_cfg = (awaddr_ff == ADDR_CFG);
  wire wr_cmd = (awaddr_ff == ADDR_CMD);
  wire wr_qry = (awaddr_ff == ADDR_QRY);
  wire wr_ro = (awaddr_ff == ADDR_STAT) || (awaddr_ff == ADDR_POS) ||
               (awaddr_ff == ADDR_CNT) || (awaddr_ff == ADDR_ROLE);
  wire wr_hit = wr_tbl || wr_cfg || wr_cmd || wr_qry || wr_ro;

  wire rd_tbl = (s_axi_araddr[7:5] == TBL_PAGE) && (s_axi_araddr[4:2] <= LAST_SEC);
  wire rd_hit = rd_tbl || (s_axi_araddr == ADDR_CFG) || (s_axi_araddr == ADDR_CMD) ||
                (s_axi_araddr == ADDR_STAT) || (s_axi_araddr == ADDR_POS) ||
                (s_axi_araddr == ADDR_CNT) || (s_axi_araddr == ADDR_ROLE) ||
                (s_axi_araddr == ADDR_QRY);

  wire [31:0] cfg_word = {21'h0, sel_ff, 4'h0, m_ff};
  wire [31:0] cfg_new = apply_strb(cfg_word, wdata_ff, wstrb_ff);
  wire [3:0] m_new = cfg_new[CFG_M_LSB +: 4];
  wire [2:0] sel_new = cfg_new[CFG_SEL_LSB +: 3];
  wire [31:0] qry_new = apply_strb({22'h0, qry_ff}, wdata_ff, wstrb_ff);
  wire [31:0] cmd_new = apply_strb(32'h0, wdata_ff, wstrb_ff);
  wire start_fill = do_wr && wr_cmd && cmd_new[CMD_FILL_BIT];
  wire start_dec = do_wr && wr_cmd && cmd_new[CMD_DEC_BIT];
  wire m_bad = (m_ff < M_MIN) || (m_ff > M_MAX);

  // ------------------------------------------------------------
  // table memory
  // ------------------------------------------------------------
  wire fill_wr = (eng_ff == ENG_FILL);
  wire [31:0] fill_data = gen_entry(fill_idx_ff, m_ff);
  wire tbl_we = fill_wr || (do_wr && wr_tbl);
  wire [2:0] tbl_widx = fill_wr ? fill_idx_ff : awaddr_ff[4:2];
  wire [31:0] tbl_wdata = fill_wr ? fill_data : apply_strb(32'h0, wdata_ff, wstrb_ff);
  wire [2:0] tbl_ridx = (eng_ff == ENG_FETCH) ? sel_ff : s_axi_araddr[4:2];
  logic [31:0] tbl_rdata;

  pbm_tbl_mem u_tbl (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(tbl_we),
    .wr_idx(tbl_widx),
    .wr_data(tbl_wdata),
    .rd_idx(tbl_ridx),
    .rd_data(tbl_rdata)
  );

  // ------------------------------------------------------------
  // entry decode
  // ------------------------------------------------------------
  wire [7:0] f_type = tbl_rdata[F_TYPE +: 8];
  wire [7:0] f_cnt = tbl_rdata[F_CNT +: 8];
  wire [7:0] f_start = tbl_rdata[F_START +: 8];
  wire [7:0] f_end = tbl_rdata[F_END +: 8];
  wire [POS_W-1:0] calc_start = bit_pos(f_start, m_ff);
  wire [POS_W-1:0] calc_end = bit_pos(f_end, m_ff);
  wire [POS_W-1:0] cnt_pow = (f_cnt[7:4] != 4'h0) ? '0 : pow2(f_cnt[3:0]);
  wire [POS_W-1:0] calc_blocks = (f_type == TYPE_64K) ? cnt_pow - LARGE_LESS : cnt_pow;
  wire calc_span_bad = (calc_end - calc_start + 10'h001) != calc_blocks;
  wire calc_type_bad = (f_type == 8'h00) || (f_type > TYPE_4TH);

  // ------------------------------------------------------------
  // lock role of the queried bit
  // ------------------------------------------------------------
  wire in_small = dec_valid_ff && (type_ff == TYPE_8K) &&
                  (qry_ff >= start_pos_ff) && (qry_ff <= end_pos_ff);
  wire role_rd = in_small && qry_ff[0];
  wire role_wr = in_small && !qry_ff[0];

  // ------------------------------------------------------------
  // engine
  // ------------------------------------------------------------
  always_comb begin
    nxt_eng = eng_ff;
    unique case (eng_ff)
      ENG_IDLE: begin
        if (start_fill) begin
          nxt_eng = ENG_FILL;
        end else if (start_dec) begin
          nxt_eng = ENG_FETCH;
        end
      end
      ENG_FILL: begin
        if (fill_idx_ff == LAST_SEC) begin
          nxt_eng = ENG_FETCH;
        end
      end
      ENG_FETCH: nxt_eng = ENG_CALC;
      ENG_CALC: nxt_eng = ENG_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eng_ff <= ENG_IDLE;
      fill_idx_ff <= 3'h0;
    end else begin
      eng_ff <= nxt_eng;
      fill_idx_ff <= fill_wr ? fill_idx_ff + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_pos_ff <= '0;
      end_pos_ff <= '0;
      blocks_ff <= '0;
      type_ff <= 8'h0;
      span_bad_ff <= 1'b0;
      type_bad_ff <= 1'b0;
      dec_valid_ff <= 1'b0;
    end else if (eng_ff == ENG_CALC) begin
      start_pos_ff <= calc_start;
      end_pos_ff <= calc_end;
      blocks_ff <= calc_blocks;
      type_ff <= f_type;
      span_bad_ff <= calc_span_bad;
      type_bad_ff <= calc_type_bad;
      dec_valid_ff <= !calc_type_bad;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_ff <= M_RST;
      sel_ff <= SEL_RST;
      qry_ff <= '0;
    end else if (do_wr) begin
      if (wr_cfg) begin
        m_ff <= m_new;
        sel_ff <= (sel_new <= LAST_SEC) ? sel_new : sel_ff;
      end
      if (wr_qry) begin
        qry_ff <= qry_new[POS_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // write channels
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready = !w_full_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[AW-1:2], 2'b00};
      end
      if (w_hs) begin
        w_full_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ------------------------------------------------------------
  // read channels
  // ------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff && !rd_pend_ff && eng_idle;

  wire [31:0] reg_rdata =
    (s_axi_araddr == ADDR_CFG) ? cfg_word :
    (s_axi_araddr == ADDR_STAT) ? {27'h0, dec_valid_ff, type_bad_ff, span_bad_ff,
                                   m_bad, !eng_idle} :
    (s_axi_araddr == ADDR_POS) ? {6'h0, end_pos_ff, 6'h0, start_pos_ff} :
    (s_axi_araddr == ADDR_CNT) ? {14'h0, type_ff, blocks_ff} :
    (s_axi_araddr == ADDR_ROLE) ? {29'h0, in_small, role_wr, role_rd} :
    (s_axi_araddr == ADDR_QRY) ? {22'h0, qry_ff} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else if (ar_hs && rd_tbl) begin
      rd_pend_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= reg_rdata;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rd_pend_ff) begin
      rd_pend_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= tbl_rdata;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_fill_length: assert property (
    $rose(eng_ff == ENG_FILL) |-> (eng_ff == ENG_FILL)[*5] ##1 (eng_ff == ENG_FETCH))
    else $error("fill did not write five entries");

  chk_bottom_small: assert property (
    (fill_wr && fill_idx_ff == 3'h0) |-> tbl_we && tbl_wdata == 32'h04ff0201)
    else $error("bottom small entry wrong");

  chk_medium_lower: assert property (
    (fill_wr && fill_idx_ff == 3'h1) |-> tbl_wdata == 32'hfdfd0002)
    else $error("lower medium entry wrong");

  chk_large_entry: assert property (
    (fill_wr && fill_idx_ff == 3'h2) |->
      tbl_wdata[15:0] == {4'h0, m_ff, 8'h03} && tbl_wdata[31:16] == 16'hfc00)
    else $error("large entry wrong");

  chk_top_small: assert property (
    (fill_wr && fill_idx_ff == 3'h4) |-> tbl_wdata == 32'h0e070201)
    else $error("top small entry wrong");

  chk_decode_time: assert property (
    (eng_ff == ENG_FETCH) |=> (eng_ff == ENG_CALC) ##1 (eng_ff == ENG_IDLE))
    else $error("decode did not finish in two cycles");

  chk_zero_start: assert property (
    (eng_ff == ENG_CALC && f_start == 8'h00) |=> start_pos_ff == 10'h000)
    else $error("zero start field not bit zero");

  chk_signed_end: assert property (
    (eng_ff == ENG_CALC && f_end != 8'h00) |=>
      end_pos_ff == (10'h001 << m_ff) + 10'h001 + {{2{$past(f_end[7])}}, $past(f_end)})
    else $error("end position formula wrong");

  chk_span_flag: assert property (
    (eng_ff == ENG_CALC) |=>
      span_bad_ff == ((end_pos_ff - start_pos_ff + 10'h001) != blocks_ff))
    else $error("span flag wrong");

  chk_type_flag: assert property (
    (eng_ff == ENG_CALC && (f_type == 8'h00 || f_type > 8'h04)) |=> type_bad_ff && !dec_valid_ff)
    else $error("bad type not flagged");

  chk_lock_parity: assert property (
    (role_rd |-> qry_ff[0] && !role_wr) and (role_wr |-> !qry_ff[0] && type_ff == 8'h01))
    else $error("lock role parity wrong");

  chk_write_resp: assert property (
    do_wr |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");
endmodule // pbm_decoder

// [pbm_host_model.sv]
// host controller model: axi4-lite master tasks for the register bus
`timescale 1ns/1ps
module pbm_host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int to_count = 0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ------------------------------------------------------------
  // bus cycles: handshakes sampled before the edge, changes after it
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    logic [1:0] br;
    int n;
    n = 0;
    tb = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 200) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        r = br;
      end
      n++;
    end
    if (!tb) to_count++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    tr = 1'b0;
    r = 2'h3;
    d = '0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && n < 200) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      n++;
    end
    if (!tr) to_count++;
  endtask
endmodule // pbm_host_model

// [test_protection_bit_map_decoder.sv]
// self-checking testbench for the protection bit map decoder
`timescale 1ns/1ps
module test_protection_bit_map_decoder;
  import pbm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count = 0;
  int cmp_count = 0;
  // expected section layout, bottom up
  logic [7:0] typ [5] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h01};
  logic [7:0] sf [5] = '{8'hff, 8'hfd, 8'h00, 8'hfe, 8'h07};
  logic [7:0] ef [5] = '{8'h04, 8'hfd, 8'hfc, 8'hfe, 8'h0e};
  logic [7:0] cc [5] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h02};
  always #50 aclk = ~aclk;
  pbm_decoder dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  pbm_host_model host (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  // ------------------------------------------------------------
  // compare and access helpers
  // ------------------------------------------------------------
  function automatic logic [9:0] bitpos(input int m, input logic [7:0] c);
    return (c == 8'h00) ? 10'h000 : 10'((1 << m) + 1 + int'($signed(c)));
  endfunction
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] v);
    cmp_count++;
    if (v !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk_word($sformatf("rdata at %h", a), e, d);
    chk_resp($sformatf("rresp at %h", a), er, r);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    host.wr(a, d, r);
    chk_resp($sformatf("bresp at %h", a), er, r);
  endtask
  task automatic run_cmd(input logic [31:0] cmd, output logic [31:0] st);
    logic [1:0] r;
    int n;
    n = 0;
    st = 32'h1;
    wr_chk(ADDR_CMD, cmd, 2'h0);
    while (st[0] !== 1'b0 && n < 50) begin
      host.rd(ADDR_STAT, st, r);
      n++;
    end
    chk_word("busy", 32'h0, {31'h0, st[0]});
  endtask
  task automatic close_out;
    err_count += host.to_count;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] st;
    logic [9:0] cnt;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(ADDR_CFG, 32'h0000_0007, 2'h0);
    rd_chk(8'h1c, 32'h0, 2'h2);
    wr_chk(8'h1c, 32'hffff_ffff, 2'h2);
    rd_chk(ADDR_CMD, 32'h0, 2'h0);
    for (int m = 4; m <= 8; m++) begin
      cc[2] = 8'(m);
      wr_chk(ADDR_CFG, 32'(m), 2'h0);
      run_cmd(32'h1, st);
      for (int s = 0; s < 5; s++) begin
        rd_chk(8'h20 + 8'(4 * s), {ef[s], sf[s], cc[s], typ[s]}, 2'h0);
        wr_chk(ADDR_CFG, (32'(s) << 8) | 32'(m), 2'h0);
        run_cmd(32'h2, st);
        chk_word("stat", (typ[s] == 8'h01) ? 32'h14 : 32'h10, st);
        cnt = (typ[s] == 8'h03) ? 10'((1 << m) - 2) : 10'(1 << cc[s]);
        rd_chk(ADDR_CNT, {14'h0, typ[s], cnt}, 2'h0);
        rd_chk(ADDR_POS, {6'h0, bitpos(m, ef[s]), 6'h0, bitpos(m, sf[s])}, 2'h0);
      end
    end
    wr_chk(ADDR_QRY, 32'd265, 2'h0);
    rd_chk(ADDR_ROLE, 32'h5, 2'h0);
    wr_chk(ADDR_QRY, 32'd266, 2'h0);
    rd_chk(ADDR_ROLE, 32'h6, 2'h0);
    wr_chk(ADDR_QRY, 32'd10, 2'h0);
    rd_chk(ADDR_ROLE, 32'h0, 2'h0);
    // zero type code in an entry and an exponent above range are both flagged
    wr_chk(8'h24, 32'h0, 2'h0);
    wr_chk(ADDR_CFG, 32'h0000_0109, 2'h0);
    wr_chk(ADDR_CFG, 32'h0000_0709, 2'h0);
    rd_chk(ADDR_CFG, 32'h0000_0109, 2'h0);
    rd_chk(8'h24, 32'h0, 2'h0);
    run_cmd(32'h2, st);
    chk_word("stat", 32'h0000_000a, st);
    close_out();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    close_out();
  end
endmodule // test_protection_bit_map_decoder
